/* rtl/wdt_params.svh */
`ifndef WDT_PARAMS_SVH
`define WDT_PARAMS_SVH
// ****************************************************************
// Register word indices; byte address is four times the index.
// ****************************************************************
`define CFG_IDX 10'h000
`define IRQ_STAT_IDX 10'h001
`define IRQ_MASK_IDX 10'h002
`define SERVICE_KEY_IDX 10'h0b5
`define TIMER_CTRL_IDX 10'h0b6
// ****************************************************************
// Field positions.
// ****************************************************************
`define CFG_ARM_BIT 0
`define CFG_IDLE_BIT 1
`define CFG_PROG_BIT 2
`define CFG_LOCK_BIT 3
`define TCTRL_IRQ_EN_BIT 0
`define TCTRL_FLAG_BIT 1
`define TCTRL_WAKE_EN_BIT 7
`define EV_BASE_OVF_BIT 0
`define EV_IDLE_WAKE_BIT 1
`define EV_WD_FAULT_BIT 2
// ****************************************************************
// Values and counts.
// ****************************************************************
`define SERVICE_KEY 8'h1b
`define RESTART_ADDR 12'hc00
`define BASE_RESET 12'h000
`define WD_FIRST_OK 4'h1
`define WD_LAST_OK 4'he
`define WD_LAST_COUNT 4'hf
`define RESET_DELAY_CYCLES 16
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

/* rtl/wdt_pkg.sv */
package wdt_pkg;
    typedef enum logic [2:0]
    {
        MODE_RUN = 3'b001,
        MODE_IDLE = 3'b010,
        MODE_SYS_RESET = 3'b100
    } mode_t;

    typedef struct packed
    {
        logic [2:0] sync1;
        logic [2:0] sync2;
        mode_t mode;
        logic [15:0] rst_cnt;
        logic [11:0] base;
        logic idle_ext;
        logic [3:0] wd_count;
        logic arm;
        logic ovf_flag;
        logic tmr_irq_en;
        logic wake_irq_en;
        logic [2:0] ev_stat;
        logic [2:0] ev_mask;
        logic aw_ok;
        logic [9:0] aw_idx;
        logic w_ok;
        logic [7:0] w_data;
        logic w_lane0;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [7:0] rdata;
        logic [1:0] rresp;
        logic irq;
        logic base_irq;
        logic sys_reset;
    } state_t;
endpackage : wdt_pkg

/* rtl/idle_and_watchdog_timer_ext.sv */
`include "wdt_params.svh"

module idle_and_watchdog_timer_ext #(
    parameter int RESET_DELAY = `RESET_DELAY_CYCLES,
    parameter bit ARM_DEFAULT = 1'b1
)
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // AXI4-Lite write address
    input wire logic awvalid,
    output logic awready,
    input wire logic [11:0] awaddr,
    input wire logic [2:0] awprot,
    // AXI4-Lite write data
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    // AXI4-Lite write response
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // AXI4-Lite read address
    input wire logic arvalid,
    output logic arready,
    input wire logic [11:0] araddr,
    input wire logic [2:0] arprot,
    // AXI4-Lite read data
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // Device pins and mode straps
    input wire logic pin_edge_waker,
    input wire logic prog_mode,
    input wire logic memory_write_lock,
    // Device outputs
    output logic idle_mode,
    output logic system_reset,
    output logic [11:0] restart_addr,
    output logic base_timer_irq,
    output logic irq
);

    wdt_pkg::state_t st;
    wdt_pkg::state_t next_st;

    logic wake_pin;
    logic in_prog;
    logic lock_on;
    logic base_wrap;
    logic idle_wrap;
    logic wd_expire;
    logic wr_fire;
    logic wr_hit;
    logic rd_hit;
    logic key_write;
    logic key_match;
    logic service_ok;
    logic service_bad;
    logic [9:0] ar_idx;
    logic [2:0] events;

    // ****************************************************************
    // Derived conditions.
    // ****************************************************************
    assign wake_pin = st.sync2[0];
    assign in_prog = st.sync2[1];
    assign lock_on = st.sync2[2];
    assign ar_idx = araddr[11:2];

    always_comb
    begin
        base_wrap = (st.base == 12'hfff);
        // idle bit wraps on second base overflow
        idle_wrap = base_wrap && st.idle_ext;
        wd_expire = base_wrap && (st.wd_count == `WD_LAST_COUNT);
        wr_fire = st.aw_ok && st.w_ok && !st.bvalid;
        wr_hit = (st.aw_idx == `CFG_IDX) || (st.aw_idx == `IRQ_STAT_IDX)
            || (st.aw_idx == `IRQ_MASK_IDX)
            || (st.aw_idx == `SERVICE_KEY_IDX)
            || (st.aw_idx == `TIMER_CTRL_IDX);
        rd_hit = (ar_idx == `CFG_IDX) || (ar_idx == `IRQ_STAT_IDX)
            || (ar_idx == `IRQ_MASK_IDX) || (ar_idx == `SERVICE_KEY_IDX)
            || (ar_idx == `TIMER_CTRL_IDX);
        key_write = wr_fire && st.w_lane0
            && (st.aw_idx == `SERVICE_KEY_IDX);
        // only the exact key counts as a service
        key_match = key_write && (st.w_data == `SERVICE_KEY);
        // window of counts one to fourteen
        service_ok = key_match && (st.wd_count >= `WD_FIRST_OK)
            && (st.wd_count <= `WD_LAST_OK);
        service_bad = key_match && !service_ok;
        events = 3'h0;
        events[`EV_BASE_OVF_BIT] = base_wrap;
        events[`EV_IDLE_WAKE_BIT] = wake_pin
            && (st.mode == wdt_pkg::MODE_IDLE);
        events[`EV_WD_FAULT_BIT] = wd_expire || service_bad;
    end

    // ****************************************************************
    // Next state.
    // ****************************************************************
    always_comb
    begin
        next_st = st;
        next_st.sync1 = {memory_write_lock, prog_mode, pin_edge_waker};
        next_st.sync2 = st.sync1;

        // Timers.
        // free-running base counter
        next_st.base = st.base + 12'h001;
        if (base_wrap)
        begin
            next_st.idle_ext = !st.idle_ext;
            next_st.wd_count = st.wd_count + 4'h1;
        end
        if (service_ok)
        begin
            next_st.wd_count = 4'h0;
        end

        // flag sets on wrap, write 0 clears, set wins
        if (wr_fire && st.w_lane0 && (st.aw_idx == `TIMER_CTRL_IDX))
        begin
            next_st.tmr_irq_en = st.w_data[`TCTRL_IRQ_EN_BIT];
            next_st.wake_irq_en = st.w_data[`TCTRL_WAKE_EN_BIT];
            if (!st.w_data[`TCTRL_FLAG_BIT])
            begin
                next_st.ovf_flag = 1'b0;
            end
        end
        if (base_wrap)
        begin
            next_st.ovf_flag = 1'b1;
        end

        // Configuration writes.
        if (wr_fire && st.w_lane0 && (st.aw_idx == `CFG_IDX))
        begin
            // arm bit changes only in programming mode
            if (in_prog)
            begin
                // clearing blocked while write lock is on
                if (st.w_data[`CFG_ARM_BIT] || !lock_on)
                begin
                    next_st.arm = st.w_data[`CFG_ARM_BIT];
                end
            end
            if (st.w_data[`CFG_IDLE_BIT] && (st.mode == wdt_pkg::MODE_RUN))
            begin
                next_st.mode = wdt_pkg::MODE_IDLE;
            end
        end

        // Sticky events and mask; a new event wins over its clear.
        if (wr_fire && st.w_lane0 && (st.aw_idx == `IRQ_STAT_IDX))
        begin
            next_st.ev_stat = st.ev_stat & ~st.w_data[2:0];
        end
        if (wr_fire && st.w_lane0 && (st.aw_idx == `IRQ_MASK_IDX))
        begin
            next_st.ev_mask = st.w_data[2:0];
        end
        next_st.ev_stat = next_st.ev_stat | events;

        // Idle wake.
        if (st.mode == wdt_pkg::MODE_IDLE)
        begin
            // pin waker or idle timer ends idle
            // execution resumes on the next clock
            if (wake_pin || idle_wrap)
            begin
                next_st.mode = wdt_pkg::MODE_RUN;
            end
        end

        // expiry resets the system only when armed
        // early or late service also resets
        if (st.arm && (wd_expire || service_bad))
        begin
            next_st.mode = wdt_pkg::MODE_SYS_RESET;
            next_st.rst_cnt = 16'(RESET_DELAY);
        end

        // AXI4-Lite write channel: address and data taken in either order.
        next_st.awready = !st.aw_ok && !st.bvalid
            && !(awvalid && st.awready);
        next_st.wready = !st.w_ok && !st.bvalid
            && !(wvalid && st.wready);
        if (awvalid && st.awready)
        begin
            next_st.aw_ok = 1'b1;
            next_st.aw_idx = awaddr[11:2];
        end
        if (wvalid && st.wready)
        begin
            next_st.w_ok = 1'b1;
            next_st.w_data = wdata[7:0];
            next_st.w_lane0 = wstrb[0];
        end
        if (wr_fire)
        begin
            next_st.bvalid = 1'b1;
            next_st.bresp = wr_hit ? `RESP_OKAY : `RESP_SLVERR;
            next_st.aw_ok = 1'b0;
            next_st.w_ok = 1'b0;
        end
        if (st.bvalid && bready)
        begin
            next_st.bvalid = 1'b0;
            next_st.awready = 1'b1;
            next_st.wready = 1'b1;
        end

        // AXI4-Lite read channel.
        next_st.arready = !st.rvalid && !(arvalid && st.arready);
        if (arvalid && st.arready)
        begin
            next_st.rvalid = 1'b1;
            next_st.rresp = rd_hit ? `RESP_OKAY : `RESP_SLVERR;
            next_st.rdata = 8'h00;
            unique case (ar_idx)
                `CFG_IDX:
                begin
                    next_st.rdata[`CFG_ARM_BIT] = st.arm;
                    next_st.rdata[`CFG_IDLE_BIT] =
                        (st.mode == wdt_pkg::MODE_IDLE);
                    next_st.rdata[`CFG_PROG_BIT] = in_prog;
                    next_st.rdata[`CFG_LOCK_BIT] = lock_on;
                end
                `IRQ_STAT_IDX: next_st.rdata[2:0] = st.ev_stat;
                `IRQ_MASK_IDX: next_st.rdata[2:0] = st.ev_mask;
                // idle and watchdog counts stay hidden
                // only the overflow flag is observable
                `TIMER_CTRL_IDX:
                begin
                    next_st.rdata[`TCTRL_IRQ_EN_BIT] = st.tmr_irq_en;
                    next_st.rdata[`TCTRL_FLAG_BIT] = st.ovf_flag;
                    next_st.rdata[`TCTRL_WAKE_EN_BIT] = st.wake_irq_en;
                end
                default: next_st.rdata = 8'h00;
            endcase
        end
        if (st.rvalid && rready)
        begin
            next_st.rvalid = 1'b0;
            next_st.arready = 1'b1;
        end

        // system reset holds timers, flags and masks cleared for the delay; fault bit set, arm bit kept
        if (st.mode == wdt_pkg::MODE_SYS_RESET)
        begin
            next_st.base = `BASE_RESET;
            next_st.idle_ext = 1'b0;
            next_st.wd_count = 4'h0;
            next_st.ovf_flag = 1'b0;
            next_st.tmr_irq_en = 1'b0;
            next_st.wake_irq_en = 1'b0;
            next_st.ev_stat = 3'h0;
            next_st.ev_stat[`EV_WD_FAULT_BIT] = 1'b1;
            next_st.ev_mask = 3'h0;
            next_st.rst_cnt = st.rst_cnt - 16'h0001;
            if (st.rst_cnt <= 16'h0001)
            begin
                next_st.mode = wdt_pkg::MODE_RUN;
            end
        end

        next_st.sys_reset = (next_st.mode == wdt_pkg::MODE_SYS_RESET);
        next_st.irq = |(next_st.ev_stat & next_st.ev_mask);
        next_st.base_irq = next_st.ovf_flag && next_st.tmr_irq_en;
    end

    // ****************************************************************
    // State register.
    // ****************************************************************
    // The arm bit stands for a non-volatile cell: only the power-on
    // reset loads it, a watchdog reset leaves it untouched.
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st <= '0;
            st.mode <= wdt_pkg::MODE_RUN;
            st.base <= `BASE_RESET;
            st.arm <= ARM_DEFAULT;
            st.awready <= 1'b1;
            st.wready <= 1'b1;
            st.arready <= 1'b1;
        end
        else
        begin
            st <= next_st;
        end
    end

    // ****************************************************************
    // Outputs.
    // ****************************************************************
    assign awready = st.awready;
    assign wready = st.wready;
    assign bvalid = st.bvalid;
    assign bresp = st.bresp;
    assign arready = st.arready;
    assign rvalid = st.rvalid;
    assign rdata = {24'h000000, st.rdata};
    assign rresp = st.rresp;
    assign idle_mode = (st.mode == wdt_pkg::MODE_IDLE);
    assign system_reset = st.sys_reset;
    assign restart_addr = `RESTART_ADDR;
    assign base_timer_irq = st.base_irq;
    assign irq = st.irq;

endmodule : idle_and_watchdog_timer_ext

/* verification/wdt_assertions.sv */
module wdt_checker #(
    parameter int RESET_DELAY = 16
)
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Register bus handshakes
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic [31:0] rdata,
    // Device pins and outputs
    input wire logic pin_edge_waker,
    input wire logic idle_mode,
    input wire logic system_reset,
    input wire logic [11:0] restart_addr,
    input wire logic base_timer_irq
);
    // ****************************************************************
    // Run lengths of reset pulse and idle stay
    // ****************************************************************
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    logic [15:0] sr_len;
    logic [13:0] idle_len;
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sr_len <= 16'h0000;
            idle_len <= 14'h0000;
        end
        else
        begin
            sr_len <= system_reset ? sr_len + 16'h0001 : 16'h0000;
            idle_len <= idle_mode ? idle_len + 14'h0001 : 14'h0000;
        end
    end
    a_restart_fixed: assert property (restart_addr == 12'hc00)
        else $error("restart address wrong");
    a_reset_length: assert property (
        $fell(system_reset) |-> sr_len == 16'(RESET_DELAY))
        else $error("reset pulse length wrong");
    a_reset_clears: assert property (
        $rose(system_reset) |-> ##2 !idle_mode && !base_timer_irq)
        else $error("reset left state behind");
    a_idle_bounded: assert property (idle_len <= 14'h2002)
        else $error("idle stay too long");
    a_pin_wakes: assert property (pin_edge_waker [*6] |-> !idle_mode)
        else $error("pin did not wake");
    a_write_answer: assert property (
        awvalid && awready && wvalid && wready |-> ##2 bvalid)
        else $error("write response late");
    a_read_answer: assert property (arvalid && arready |=> rvalid)
        else $error("read response late");
    a_read_holds: assert property (
        rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data dropped");
    a_no_accept: assert property (bvalid |-> !awready && !wready)
        else $error("write taken during response");
endmodule : wdt_checker

bind idle_and_watchdog_timer_ext wdt_checker #(.RESET_DELAY(RESET_DELAY)) i_chk (
    .ref_clk(ref_clk), .rst_n(rst_n), .awvalid(awvalid), .awready(awready),
    .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready),
    .arvalid(arvalid), .arready(arready), .rvalid(rvalid), .rready(rready),
    .rdata(rdata), .pin_edge_waker(pin_edge_waker), .idle_mode(idle_mode),
    .system_reset(system_reset), .restart_addr(restart_addr),
    .base_timer_irq(base_timer_irq));

/* verification/idle_and_watchdog_timer_ext_tb_top.sv */
`include "wdt_params.svh"
module idle_and_watchdog_timer_ext_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [11:0] CFG = {`CFG_IDX, 2'b00};
    localparam logic [11:0] STAT = {`IRQ_STAT_IDX, 2'b00};
    localparam logic [11:0] MASK = {`IRQ_MASK_IDX, 2'b00};
    localparam logic [11:0] KEY = {`SERVICE_KEY_IDX, 2'b00};
    localparam logic [11:0] TCTL = {`TIMER_CTRL_IDX, 2'b00};
    logic ref_clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic pin_edge_waker, prog_mode, memory_write_lock;
    logic idle_mode, system_reset, base_timer_irq;
    logic [11:0] awaddr, araddr, restart_addr;
    logic [31:0] wdata, rdata, d;
    logic [1:0] bresp, rresp, r;
    int fail_count = 0;
    int cmp_count = 0;
    int cyc = 0;
    int n;

    idle_and_watchdog_timer_ext i_dut (.ref_clk(ref_clk), .rst_n(rst_n),
        .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(3'h0),
        .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'hf),
        .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
        .arready(arready), .araddr(araddr), .arprot(3'h0), .rvalid(rvalid),
        .rready(rready), .rdata(rdata), .rresp(rresp),
        .pin_edge_waker(pin_edge_waker), .prog_mode(prog_mode),
        .memory_write_lock(memory_write_lock), .idle_mode(idle_mode),
        .system_reset(system_reset), .restart_addr(restart_addr),
        .base_timer_irq(base_timer_irq), .irq(irq));

    // ****************************************************************
    // Bus tasks, comparisons and closing report
    // ****************************************************************
    task automatic test_done();
        $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : test_done

    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("Error at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : check_word

    task automatic check_bit(input logic got, input logic exp);
        check_word({31'h0, got}, {31'h0, exp});
    endtask : check_bit

    // Every write must complete with an OKAY response.
    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        logic done;
        done = 1'b0;
        @(posedge ref_clk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!done)
        begin
            @(posedge ref_clk);
            if (awvalid && awready)
                awvalid <= 1'b0;
            if (wvalid && wready)
                wvalid <= 1'b0;
            done = bvalid === 1'b1;
        end
        bready <= 1'b0;
        check_word({29'h0, done, bresp}, {29'h0, 1'b1, `RESP_OKAY});
    endtask : wr

    task automatic rd(input logic [11:0] a, output logic [31:0] v,
                      output logic [1:0] rs);
        logic done;
        done = 1'b0;
        @(posedge ref_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!done)
        begin
            @(posedge ref_clk);
            if (arvalid && arready)
                arvalid <= 1'b0;
            done = rvalid === 1'b1;
        end
        v = rdata;
        rs = rresp;
        rready <= 1'b0;
        check_bit(done, 1'b1);
    endtask : rd

    initial
    begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    // A hang is cut short well after the long expiry wait.
    always @(posedge ref_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 90000)
        begin
            fail_count++;
            test_done();
        end
    end

    initial
    begin
        {rst_n, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
        {pin_edge_waker, prog_mode, memory_write_lock} = 3'h0;
        {awaddr, araddr, wdata} = 56'h0;
        repeat (12) @(posedge ref_clk);
        rst_n <= 1'b1;
        rd(CFG, d, r);
        check_word(d, 32'h00000001);
        rd(KEY, d, r);
        check_word(d, 32'h00000000);
        rd(12'h100, d, r);
        check_word({30'h0, r}, {30'h0, `RESP_SLVERR});
        wr(KEY, 32'h00000055);
        repeat (3) @(posedge ref_clk);
        check_bit(system_reset, 1'b0);
        wr(KEY, 32'h0000001b);
        for (n = 0; n < 4 && system_reset !== 1'b1; n++) @(posedge ref_clk);
        check_bit(system_reset, 1'b1);
        check_word({20'h0, restart_addr}, 32'h00000c00);
        for (n = 0; n < 40 && system_reset !== 1'b0; n++) @(posedge ref_clk);
        rd(STAT, d, r);
        check_word(d, 32'h00000004);
        wr(MASK, 32'h00000004);
        repeat (2) @(posedge ref_clk);
        check_bit(irq, 1'b1);
        wr(STAT, 32'h00000004);
        repeat (2) @(posedge ref_clk);
        check_bit(irq, 1'b0);
        $display("Test early service done");
        d = 32'h0;
        for (n = 0; n < 2000 && d[1] !== 1'b1; n++) rd(TCTL, d, r);
        check_word(d, 32'h00000002);
        wr(TCTL, 32'h00000003);
        repeat (2) @(posedge ref_clk);
        check_bit(base_timer_irq, 1'b1);
        wr(TCTL, 32'h00000001);
        rd(TCTL, d, r);
        check_word(d, 32'h00000001);
        wr(KEY, 32'h0000001b);
        repeat (4) @(posedge ref_clk);
        check_bit(system_reset, 1'b0);
        $display("Test overflow flag and service done");
        wr(CFG, 32'h00000003);
        repeat (2) @(posedge ref_clk);
        check_bit(idle_mode, 1'b1);
        for (n = 0; n < 8200 && idle_mode !== 1'b0; n++) @(posedge ref_clk);
        check_bit(idle_mode, 1'b0);
        rd(STAT, d, r);
        check_word(d & 32'h2, 32'h00000000);
        wr(CFG, 32'h00000003);
        pin_edge_waker <= 1'b1;
        for (n = 0; n < 8 && idle_mode !== 1'b0; n++) @(posedge ref_clk);
        check_bit(idle_mode, 1'b0);
        repeat (6) @(posedge ref_clk);
        pin_edge_waker <= 1'b0;
        rd(STAT, d, r);
        check_word(d & 32'h2, 32'h00000002);
        $display("Test idle wake done");
        wr(CFG, 32'h00000000);
        rd(CFG, d, r);
        check_word(d, 32'h00000001);
        prog_mode <= 1'b1;
        memory_write_lock <= 1'b1;
        repeat (4) @(posedge ref_clk);
        wr(CFG, 32'h00000000);
        rd(CFG, d, r);
        check_word(d, 32'h0000000d);
        memory_write_lock <= 1'b0;
        repeat (4) @(posedge ref_clk);
        wr(CFG, 32'h00000000);
        rd(CFG, d, r);
        check_word(d, 32'h00000004);
        prog_mode <= 1'b0;
        wr(KEY, 32'h0000001b);
        rd(STAT, d, r);
        check_word(d & 32'h4, 32'h00000000);
        wr(KEY, 32'h0000001b);
        repeat (4) @(posedge ref_clk);
        check_bit(system_reset, 1'b0);
        rd(STAT, d, r);
        check_word(d & 32'h4, 32'h00000004);
        prog_mode <= 1'b1;
        repeat (4) @(posedge ref_clk);
        wr(CFG, 32'h00000001);
        prog_mode <= 1'b0;
        $display("Test arm bit done");
        for (n = 0; n < 66000 && system_reset !== 1'b1; n++) @(posedge ref_clk);
        check_bit(system_reset, 1'b1);
        check_bit(n > 45000, 1'b1);
        for (n = 0; n < 40 && system_reset !== 1'b0; n++) @(posedge ref_clk);
        rd(CFG, d, r);
        check_word(d, 32'h00000001);
        $display("Test expiry done");
        test_done();
    end
endmodule : idle_and_watchdog_timer_ext_tb_top
